// File: loop_supervisor_map.svh
`ifndef LOOP_SUPERVISOR_MAP_SVH
`define LOOP_SUPERVISOR_MAP_SVH
// ==================================================
// register map
`define REG_CTRL 12'h000
`define REG_STATUS 12'h004
`define CTRL_LOCAL_LOOP 0
`define CTRL_REMOTE_LOOP 1
`define CTRL_PATTERN 2
`define CTRL_WIDTH 3
`define CTRL_RESET 3'h0
// ==================================================
// timing, seconds as printed
`define RESTART_TRAIN_S 50
`define RESTART_DATA_S 4
`define RESTART_TEST_S 60
`define PATTERN_TIMEOUT_S 45
`define CLK_PERIOD_NS 10
`define NS_PER_S 1000000000
`define CLK_PER_SEC (`NS_PER_S / `CLK_PERIOD_NS)
`endif

// File: loop_supervisor_pkg.sv
package loop_supervisor_pkg;
  typedef enum logic [2:0] {
    link_training_state,
    data_transfer_state,
    local_loop_1,
    local_loop_2,
    remote_loop_request,
    remote_loop_wait,
    remote_loop_active,
    remote_loop_off
  } link_state_t;
  typedef enum logic [1:0] {
    eoc_none,
    remote_loop_on_request,
    remote_loop_off_request,
    remote_loop_ack
  } eoc_code_t;
endpackage

// File: loopback_test_supervisor.sv
// Overview of operation
// RULE_01: restart after unframed run, 50/4/60 seconds
// RULE_02: pattern stops itself after 45 seconds
// RULE_03: error indicator flashes until switch normal
// RULE_04: local loop: mode 1 unlinked, 2 linked
// RULE_05: mode 1 loops terminal data back locally
// RULE_06: mode 1 keeps peer training; release retrains
// RULE_07: mode 2 loops framer and line together
// RULE_08: mode 2 release returns to data transfer
// RULE_09: mode 1 pattern loops to the detector
// RULE_10: pattern enable lengthens own restart to 60s
// RULE_11: pattern in local loop invalidates terminal data
// RULE_12: mode 2 disables the local pattern generator
// RULE_13: remote loop request, peer acknowledge establishes
// RULE_14: remote end loops line data, ignores terminal
// RULE_15: remote end 60s restart; local 4s
// RULE_16: test indicator stays until loop-off sent
// RULE_17: switch ignored until normal during loop-off
// RULE_18: remote loop pattern checked, stops at 45s
// RULE_19: data-mode pattern unframed; peer restarts 4s
// RULE_20: clear-to-send and carrier follow framed packets
// RULE_21: one-second timebase from parameterised divider
//
// Register access over APB and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "loop_supervisor_map.svh"
module loopback_test_supervisor
  import loop_supervisor_pkg::*;
#(
  parameter int CLK_PER_SEC = `CLK_PER_SEC
) (
  input wire logic pclk, // system clock
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb write
  input wire logic [11:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error, unmapped address
  input wire logic sw_local_loop, // panel local loop switch
  input wire logic sw_remote_loop, // panel remote loop switch
  input wire logic sw_pattern, // panel pattern switch
  input wire logic term_local_loop, // terminal local loop line
  input wire logic term_remote_loop, // terminal remote loop line
  input wire logic framed_ok, // framer receives framed packets
  input wire logic pat_bit_err, // detector bit error pulse
  input wire logic eoc_tx_done, // eoc message fully sent
  input wire logic eoc_rx_on, // peer sent loop-on request
  input wire logic eoc_rx_off, // peer sent loop-off request
  input wire logic eoc_rx_ack, // peer acknowledged loop
  output logic eoc_tx_valid, // eoc message pending
  output eoc_code_t eoc_tx_code, // eoc message code
  output logic restart_link, // restart pulse to framer
  output logic framer_tx_en, // framer sends framed packets
  output logic loop_term, // loop control term tx to rx
  output logic loop_framer, // loop inside the framer
  output logic loop_line, // loop line rx back to line
  output logic pat_gen_en, // pattern generator on
  output logic pat_to_loop, // pattern via loop control
  output logic term_rx_valid, // terminal rx data valid
  output logic far_data_valid, // line data valid
  output logic term_tx_ignore, // own terminal tx ignored
  output logic cts, // clear to send
  output logic cd, // carrier detect
  output logic link_down_indicator, // no link lamp
  output logic error_indicator, // error lamp
  output logic test_active_indicator // test lamp
);
  localparam int NSYNC = 5;

  typedef struct packed {
    logic [NSYNC-1:0] sync1;
    logic [NSYNC-1:0] sync2;
    logic [`CTRL_WIDTH-1:0] ctrl;
    link_state_t st;
    logic remote_end;
    logic ack_pend;
    logic rl_block;
    logic [5:0] unframed_sec;
    logic [5:0] pat_sec;
    logic pat_timeout;
    logic restart;
    logic err;
    logic cts;
    logic [31:0] rdata;
    logic slverr;
  } sup_state_t;

  sup_state_t s_q, s_d;
  timebase_if tb ();

  logic loc_req, rem_req, pat_req, pat_run, linked, in_loop;
  logic [5:0] restart_limit;
  logic apb_wr, apb_rd, hit_ctrl, hit_status;

  if (CLK_PER_SEC < 2) begin : g_bad_rate
    $error("CLK_PER_SEC must be at least 2");
  end

  // ==================================================
  // timebase
  second_timebase #(
    .CLK_PER_SEC(CLK_PER_SEC)
  ) u_timebase ( // RULE_21
    .pclk(pclk),
    .presetn(presetn),
    .tb(tb)
  );

  // ==================================================
  // request decode
  always_comb begin
    loc_req = s_q.sync2[0] | s_q.sync2[3] | s_q.ctrl[`CTRL_LOCAL_LOOP]; // RULE_04
    rem_req = s_q.sync2[1] | s_q.sync2[4] | s_q.ctrl[`CTRL_REMOTE_LOOP]; // RULE_13
    pat_req = s_q.sync2[2] | s_q.ctrl[`CTRL_PATTERN];
    linked = s_q.st != link_training_state && s_q.st != local_loop_1;
    in_loop = s_q.st == local_loop_1 || s_q.st == local_loop_2;
    // generator has no path out while mode 2 holds the framer
    pat_run = pat_req && !s_q.pat_timeout && s_q.st != local_loop_2; // RULE_12
    if (pat_run || s_q.remote_end) begin
      restart_limit = 6'(`RESTART_TEST_S); // RULE_10 RULE_15
    end else if (s_q.st == link_training_state) begin
      restart_limit = 6'(`RESTART_TRAIN_S); // RULE_01
    end else begin
      restart_limit = 6'(`RESTART_DATA_S); // RULE_01 RULE_15 RULE_19
    end
  end

  // ==================================================
  // apb decode
  always_comb begin
    apb_wr = psel && penable && pwrite;
    apb_rd = psel && !pwrite;
    hit_ctrl = paddr == `REG_CTRL;
    hit_status = paddr == `REG_STATUS;
  end

  // ==================================================
  // next state
  always_comb begin
    s_d = s_q;
    s_d.restart = 1'b0;
    s_d.sync1 = {term_remote_loop, term_local_loop, sw_pattern, sw_remote_loop, sw_local_loop};
    s_d.sync2 = s_q.sync1;
    s_d.cts = framed_ok; // RULE_20
    s_d.err = pat_run && pat_bit_err;

    // unframed watchdog
    if (framed_ok) begin
      s_d.unframed_sec = 6'h00;
    end else if (tb.sec_tick) begin
      if (s_q.unframed_sec + 6'h01 >= restart_limit) begin
        s_d.unframed_sec = 6'h00;
        s_d.restart = 1'b1; // RULE_01
      end else begin
        s_d.unframed_sec = s_q.unframed_sec + 6'h01;
      end
    end

    // pattern timeout; switch back to normal clears it
    if (!pat_req) begin
      s_d.pat_sec = 6'h00;
      s_d.pat_timeout = 1'b0; // RULE_03
    end else if (pat_run && tb.sec_tick) begin
      if (s_q.pat_sec + 6'h01 >= 6'(`PATTERN_TIMEOUT_S)) begin
        s_d.pat_sec = 6'h00;
        s_d.pat_timeout = 1'b1; // RULE_02 RULE_18
      end else begin
        s_d.pat_sec = s_q.pat_sec + 6'h01;
      end
    end

    if (!rem_req) s_d.rl_block = 1'b0; // RULE_17
    if (s_q.ack_pend && eoc_tx_done) s_d.ack_pend = 1'b0;

    unique case (s_q.st)
      link_training_state: begin
        if (loc_req) s_d.st = local_loop_1; // RULE_04
        else if (framed_ok) s_d.st = data_transfer_state;
      end
      data_transfer_state: begin
        if (loc_req) begin
          s_d.st = local_loop_2; // RULE_04
        end else if (rem_req && !s_q.rl_block) begin
          s_d.st = remote_loop_request; // RULE_13
        end else if (eoc_rx_on) begin
          s_d.st = remote_loop_active;
          s_d.remote_end = 1'b1; // RULE_15
          s_d.ack_pend = 1'b1; // RULE_13
        end
      end
      local_loop_1: begin
        if (!loc_req) s_d.st = link_training_state; // RULE_06
      end
      local_loop_2: begin
        if (!loc_req) s_d.st = data_transfer_state; // RULE_08
      end
      remote_loop_request: begin
        if (!rem_req) s_d.st = remote_loop_off;
        else if (eoc_tx_done) s_d.st = remote_loop_wait;
      end
      remote_loop_wait: begin
        if (!rem_req) s_d.st = remote_loop_off;
        else if (eoc_rx_ack) s_d.st = remote_loop_active; // RULE_13
      end
      remote_loop_active: begin
        if (s_q.remote_end) begin
          if (eoc_rx_off) begin
            s_d.st = data_transfer_state;
            s_d.remote_end = 1'b0;
          end
        end else if (!rem_req) begin
          s_d.st = remote_loop_off; // RULE_16
        end
      end
      remote_loop_off: begin
        if (rem_req) s_d.rl_block = 1'b1; // RULE_17
        if (eoc_tx_done) s_d.st = data_transfer_state; // RULE_16
      end
    endcase

    // a lost line ends any linked mode; loops without link stay put
    if (s_q.restart && s_q.st != local_loop_1) begin
      s_d.st = link_training_state;
      s_d.remote_end = 1'b0;
      s_d.ack_pend = 1'b0;
    end

    // apb slave, zero wait states
    s_d.slverr = 1'b0;
    s_d.rdata = 32'h0;
    if (psel && !penable) begin
      if (apb_rd && hit_ctrl) begin
        s_d.rdata = 32'(s_q.ctrl);
      end else if (apb_rd && hit_status) begin
        s_d.rdata = {20'h0, s_q.rl_block, s_q.remote_end, s_q.pat_timeout, pat_run,
                     s_q.cts, linked, in_loop, 2'h0, 3'(s_q.st)};
      end
      s_d.slverr = !(hit_ctrl || hit_status);
    end else begin
      s_d.rdata = s_q.rdata;
      s_d.slverr = s_q.slverr;
    end
    if (apb_wr && hit_ctrl) s_d.ctrl = pwdata[`CTRL_WIDTH-1:0];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
      s_q.ctrl <= `CTRL_RESET;
      s_q.st <= link_training_state;
    end else begin
      s_q <= s_d;
    end
  end

  // ==================================================
  // eoc signalling
  always_comb begin
    eoc_tx_valid = 1'b1;
    eoc_tx_code = eoc_none;
    if (s_q.st == remote_loop_request) begin
      eoc_tx_code = remote_loop_on_request; // RULE_13
    end else if (s_q.st == remote_loop_off) begin
      eoc_tx_code = remote_loop_off_request; // RULE_16
    end else if (s_q.ack_pend) begin
      eoc_tx_code = remote_loop_ack; // RULE_13
    end else begin
      eoc_tx_valid = 1'b0;
    end
  end

  // ==================================================
  // data path steering
  always_comb begin
    loop_term = s_q.st == local_loop_1; // RULE_05
    loop_framer = s_q.st == local_loop_2; // RULE_07
    loop_line = s_q.st == local_loop_2 || (s_q.st == remote_loop_active && s_q.remote_end); // RULE_07 RULE_14
    term_tx_ignore = s_q.st == remote_loop_active && s_q.remote_end; // RULE_14
    framer_tx_en = s_q.st != local_loop_1; // RULE_06
    pat_gen_en = pat_run; // RULE_02 RULE_19
    pat_to_loop = pat_run && s_q.st == local_loop_1; // RULE_09
    far_data_valid = s_q.st != local_loop_1; // RULE_05
    term_rx_valid = !(pat_run && in_loop); // RULE_11
    restart_link = s_q.restart;
    cts = s_q.cts; // RULE_20
    cd = s_q.cts; // RULE_20
    prdata = s_q.rdata;
    pready = 1'b1;
    pslverr = s_q.slverr;
  end

  // ==================================================
  // indicators
  always_comb begin
    link_down_indicator = !linked;
    error_indicator = s_q.pat_timeout ? tb.blink : s_q.err; // RULE_03
    test_active_indicator = in_loop || pat_run || s_q.remote_end ||
                            s_q.st == remote_loop_request || s_q.st == remote_loop_wait ||
                            s_q.st == remote_loop_active || s_q.st == remote_loop_off; // RULE_16
  end
endmodule
`default_nettype wire

// File: loopback_test_supervisor_props.sv
`timescale 1ns/1ps
`default_nettype none
module loopback_test_supervisor_props #(
  parameter int CLK_PER_SEC = 20
) (
  input wire logic pclk, // clock
  input wire logic presetn, // reset
  input wire logic framed_ok, // framed rx
  input wire logic cts, // cts
  input wire logic cd, // carrier
  input wire logic loop_term, // mode 1 loop
  input wire logic loop_framer, // framer loop
  input wire logic loop_line, // line loop
  input wire logic pat_gen_en, // pattern on
  input wire logic pat_to_loop, // pattern path
  input wire logic term_rx_valid, // rx valid
  input wire logic far_data_valid, // line valid
  input wire logic restart_link // restart
);
  // ==========
  // run lengths
  int unsigned low_n;
  int unsigned pat_n;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_n <= 0;
      pat_n <= 0;
    end else begin
      low_n <= framed_ok ? 0 : low_n + 1;
      pat_n <= pat_gen_en ? pat_n + 1 : 0;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========
  // properties
  property p_cts_up; framed_ok |=> cts && cd; endproperty
  a_cts_up: assert property (p_cts_up) else $error("cts cd not raised");
  property p_cts_dn; !framed_ok |=> !cts && !cd; endproperty
  a_cts_dn: assert property (p_cts_dn) else $error("cts cd not dropped");
  property p_m2_both; loop_framer |-> loop_line; endproperty
  a_m2_both: assert property (p_m2_both) else $error("mode 2 single loop");
  property p_m2_nopat; loop_framer |-> !pat_gen_en; endproperty
  a_m2_nopat: assert property (p_m2_nopat) else $error("pattern in mode 2");
  property p_m1_far; loop_term |-> !far_data_valid; endproperty
  a_m1_far: assert property (p_m1_far) else $error("line data valid in mode 1");
  property p_pat_rx; pat_gen_en && (loop_term || loop_framer) |-> !term_rx_valid; endproperty
  a_pat_rx: assert property (p_pat_rx) else $error("pattern reached terminal");
  property p_pat_path; pat_gen_en && loop_term |-> pat_to_loop; endproperty
  a_pat_path: assert property (p_pat_path) else $error("pattern not looped");
  property p_pat_end; pat_gen_en |-> pat_n < 45 * CLK_PER_SEC + 4; endproperty
  a_pat_end: assert property (p_pat_end) else $error("pattern ran too long");
  // tick phase is unknown, so a 4 s limit may land after 3 whole seconds
  property p_rst_late; restart_link |-> low_n >= 3 * CLK_PER_SEC; endproperty
  a_rst_late: assert property (p_rst_late) else $error("restart too early");
endmodule
bind loopback_test_supervisor loopback_test_supervisor_props #(.CLK_PER_SEC(CLK_PER_SEC)) i_props (
  .pclk(pclk), .presetn(presetn), .framed_ok(framed_ok), .cts(cts), .cd(cd),
  .loop_term(loop_term), .loop_framer(loop_framer), .loop_line(loop_line),
  .pat_gen_en(pat_gen_en), .pat_to_loop(pat_to_loop), .term_rx_valid(term_rx_valid),
  .far_data_valid(far_data_valid), .restart_link(restart_link));
`default_nettype wire

// File: loopback_test_supervisor_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module loopback_test_supervisor_tb_top;
  import loop_supervisor_pkg::*;
  localparam int CPS = 20;
  logic pclk = 0;
  logic presetn = 0;
  logic psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic pready, pslverr, e, b;
  logic sw_local_loop = 0, sw_remote_loop = 0, sw_pattern = 0, framed_ok = 0;
  logic send_on = 0, send_off = 0;
  logic eoc_tx_done, eoc_rx_on, eoc_rx_off, eoc_rx_ack, eoc_tx_valid, restart_link, framer_tx_en;
  logic loop_term, loop_framer, loop_line, pat_gen_en, pat_to_loop, term_rx_valid, far_data_valid;
  logic term_tx_ignore, cts, cd, link_down_indicator, error_indicator, test_active_indicator;
  eoc_code_t eoc_tx_code;
  int err_total = 0, n_compared = 0, cyc = 0, n;
  always #5 pclk = ~pclk;
  loopback_test_supervisor #(.CLK_PER_SEC(CPS)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sw_local_loop(sw_local_loop), .sw_remote_loop(sw_remote_loop),
    .sw_pattern(sw_pattern), .term_local_loop(1'b0), .term_remote_loop(1'b0), .framed_ok(framed_ok),
    .pat_bit_err(1'b0), .eoc_tx_done(eoc_tx_done), .eoc_rx_on(eoc_rx_on), .eoc_rx_off(eoc_rx_off),
    .eoc_rx_ack(eoc_rx_ack), .eoc_tx_valid(eoc_tx_valid), .eoc_tx_code(eoc_tx_code),
    .restart_link(restart_link), .framer_tx_en(framer_tx_en), .loop_term(loop_term),
    .loop_framer(loop_framer), .loop_line(loop_line), .pat_gen_en(pat_gen_en), .pat_to_loop(pat_to_loop),
    .term_rx_valid(term_rx_valid), .far_data_valid(far_data_valid), .term_tx_ignore(term_tx_ignore),
    .cts(cts), .cd(cd), .link_down_indicator(link_down_indicator), .error_indicator(error_indicator),
    .test_active_indicator(test_active_indicator));
  peer_modem_model #(.DLY(20)) i_peer (.pclk(pclk), .presetn(presetn), .eoc_tx_valid(eoc_tx_valid),
    .eoc_tx_code(eoc_tx_code), .send_on(send_on), .send_off(send_off),
    .eoc_tx_done(eoc_tx_done), .eoc_rx_ack(eoc_rx_ack),
    .eoc_rx_on(eoc_rx_on), .eoc_rx_off(eoc_rx_off));
  // ==========
  // tasks
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic chk(input string s, input logic [31:0] x, input logic [31:0] g);
    n_compared++;
    if (g !== x) begin
      err_total++;
      $display("[ERR] %s exp %0h got %0h", s, x, g);
    end
  endtask
  task automatic wst(input logic [2:0] s);
    n = 0;
    do begin
      apb(0, 12'h004, 32'h0);
      n++;
    end while (r[2:0] !== s && n < 500);
    chk("state", s, r[2:0]);
  endtask
  task automatic complete_run;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      complete_run;
    end
  end
  // ==========
  // tests
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1;
    apb(0, 12'h000, 32'h0);
    chk("ctrl", 0, r);
    wst(0);
    chk("link down lamp", 1, link_down_indicator);
    apb(1, 12'h008, 32'h7);
    chk("slverr", 1, e);
    $display("test reset done");
    apb(1, 12'h000, 32'h1);
    wst(2);
    chk("loop_term", 1, loop_term);
    chk("far valid", 0, far_data_valid);
    chk("link down lamp", 1, link_down_indicator);
    chk("framer tx", 0, framer_tx_en);
    sw_pattern <= 1;
    repeat (6) @(posedge pclk);
    chk("pat path", 1, pat_to_loop);
    chk("rx valid", 0, term_rx_valid);
    n = 0;
    while (pat_gen_en === 1'b1 && n < 46 * CPS) begin
      @(posedge pclk);
      n++;
    end
    chk("pat run", 1, n >= 44 * CPS - 8 && n <= 45 * CPS);
    // blink has a half period of half a second
    n = 0;
    b = error_indicator;
    repeat (4 * CPS) begin
      @(posedge pclk);
      if (error_indicator !== b) n++;
      b = error_indicator;
    end
    chk("blink", 1, n >= 7 && n <= 9);
    sw_pattern <= 0;
    repeat (6) @(posedge pclk);
    n = 0;
    repeat (2 * CPS) begin
      @(posedge pclk);
      if (error_indicator !== 1'b0) n++;
    end
    chk("blink off", 0, n);
    apb(1, 12'h000, 32'h0);
    framed_ok <= 1;
    wst(1);
    chk("cts", 1, cts);
    chk("cd", 1, cd);
    $display("test local loop 1 done");
    sw_local_loop <= 1;
    wst(3);
    chk("mode2 loops", 3, {loop_framer, loop_line});
    sw_pattern <= 1;
    repeat (6) @(posedge pclk);
    chk("pat gen", 0, pat_gen_en);
    sw_pattern <= 0;
    sw_local_loop <= 0;
    wst(1);
    chk("mode2 loops", 0, {loop_framer, loop_line});
    $display("test local loop 2 done");
    sw_remote_loop <= 1;
    wst(6);
    chk("test lamp", 1, test_active_indicator);
    sw_remote_loop <= 0;
    wst(7);
    chk("test lamp", 1, test_active_indicator);
    chk("off code", 2, eoc_tx_code);
    sw_remote_loop <= 1;
    wst(1);
    repeat (10) @(posedge pclk);
    apb(0, 12'h004, 32'h0);
    chk("blocked", 1, r[2:0]);
    sw_remote_loop <= 0;
    $display("test remote loop done");
    repeat (6) @(posedge pclk);
    send_on <= 1;
    @(posedge pclk);
    send_on <= 0;
    wst(6);
    chk("ack code", 3, eoc_tx_code);
    chk("far loop", 3, {loop_line, term_tx_ignore});
    apb(0, 12'h004, 32'h0);
    chk("remote end", 1, r[10]);
    send_off <= 1;
    @(posedge pclk);
    send_off <= 0;
    wst(1);
    chk("far loop", 0, {loop_line, term_tx_ignore});
    $display("test remote end done");
    framed_ok <= 0;
    n = 0;
    while (restart_link !== 1'b1 && n < 6 * CPS) begin
      @(posedge pclk);
      n++;
    end
    chk("restart", 1, n >= 3 * CPS && n <= 5 * CPS + 4);
    chk("cts", 0, cts);
    chk("cd", 0, cd);
    wst(0);
    $display("test restart done");
    complete_run;
  end
endmodule
`default_nettype wire

// File: peer_modem_model.sv
`timescale 1ns/1ps
`default_nettype none
module peer_modem_model #(
  parameter int DLY = 20
) (
  input wire logic pclk, // clock
  input wire logic presetn, // reset
  input wire logic eoc_tx_valid, // message pending
  input wire loop_supervisor_pkg::eoc_code_t eoc_tx_code, // code
  input wire logic send_on, // bench asks peer to request a loop
  input wire logic send_off, // bench asks peer to end its loop
  output logic eoc_tx_done, // sent
  output logic eoc_rx_ack, // ack
  output logic eoc_rx_on, // peer loop-on
  output logic eoc_rx_off // peer loop-off
);
  import loop_supervisor_pkg::*;
  int n;
  int ack_n;
  // ==========
  // slow channel: each message takes DLY cycles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      n <= 0;
      ack_n <= 0;
      eoc_tx_done <= 0;
      eoc_rx_ack <= 0;
      eoc_rx_on <= 0;
      eoc_rx_off <= 0;
    end else begin
      eoc_tx_done <= 0;
      eoc_rx_ack <= 0;
      eoc_rx_on <= send_on;
      eoc_rx_off <= send_off;
      n <= (eoc_tx_valid && !eoc_tx_done) ? n + 1 : 0;
      if (eoc_tx_valid && !eoc_tx_done && n == DLY) begin
        eoc_tx_done <= 1;
        if (eoc_tx_code == remote_loop_on_request) ack_n <= 1;
      end
      if (ack_n != 0) ack_n <= ack_n + 1;
      if (ack_n == DLY) begin
        eoc_rx_ack <= 1;
        ack_n <= 0;
      end
    end
  end
endmodule
`default_nettype wire

// File: second_timebase.sv
`timescale 1ns/1ps
`default_nettype none
`include "loop_supervisor_map.svh"
module second_timebase #(
  parameter int CLK_PER_SEC = `CLK_PER_SEC
) (
  input wire logic pclk, // system clock
  input wire logic presetn, // async reset, active low
  timebase_if.src tb // one-second tick and blink level
);
  localparam int HALF = CLK_PER_SEC / 2;
  typedef struct packed {
    logic [31:0] cnt;
    logic half;
    logic tick;
    logic blink;
  } tb_state_t;
  tb_state_t s_q, s_d;

  if (CLK_PER_SEC < 2) begin : g_bad_rate
    $error("CLK_PER_SEC must be at least 2");
  end

  // ==================================================
  // half-second divider, tick on every second half
  always_comb begin
    s_d = s_q;
    s_d.tick = 1'b0;
    if (s_q.cnt == 32'(HALF - 1)) begin
      s_d.cnt = 32'h0;
      s_d.half = ~s_q.half;
      s_d.blink = ~s_q.blink;
      s_d.tick = s_q.half;
    end else begin
      s_d.cnt = s_q.cnt + 32'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) s_q <= '0;
    else s_q <= s_d;
  end

  assign tb.sec_tick = s_q.tick;
  assign tb.blink = s_q.blink;
endmodule
`default_nettype wire

// File: timebase_if.sv
`timescale 1ns/1ps
`default_nettype none
interface timebase_if;
  logic sec_tick;
  logic blink;
  modport src (output sec_tick, output blink);
  modport snk (input sec_tick, input blink);
endinterface
`default_nettype wire
